// *** scaa_cam_loc.sv ***
// one port cam location: 48-bit address, byte pointer and valid bit
// assumes at most one of write, read and learn strobes is offered per cycle
`timescale 1ns/1ps
module scaa_cam_loc (
    input wire logic mclk,
    input wire logic reset_n,
    scaa_loc_if.loc lif
);

    logic [47:0] addr;
    logic [2:0] ptr;
    logic valid;
    logic [47:0] next_addr;
    logic [2:0] next_ptr;
    logic next_valid;
    logic [2:0] slot;

    ////////////////////////////////////////////////////////////////////////
    // next state: byte loads advance the pointer, a valid location is locked
    always_comb begin
        slot = scaa_pkg::scaa_slot(ptr); // [R2]
        next_addr = addr;
        next_ptr = ptr;
        next_valid = valid;
        if (lif.valid_we) begin
            next_valid = lif.valid_wdata; // [R6]
        end
        if (lif.wr_stb) begin
            if (!valid) begin
                next_addr = scaa_pkg::scaa_put_byte(addr, slot, lif.wdata); // [R7]
                next_ptr = slot + 3'h1; // [R1]
            end
        end else if (lif.rd_stb) begin
            next_ptr = slot + 3'h1; // reads walk the bytes too [R7]
        end else if (lif.learn_stb && !valid) begin
            next_addr = scaa_pkg::scaa_put_byte(addr, slot, lif.learn_data);
            next_ptr = slot + 3'h1; // [R4]
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state registers, all cleared at reset
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            addr <= scaa_pkg::RESET_ADDR;
            ptr <= scaa_pkg::PTR_FIRST; // [R13]
            valid <= 1'b0; // [R13]
        end else begin
            addr <= next_addr;
            ptr <= next_ptr;
            valid <= next_valid;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // state seen by the controller
    assign lif.ptr = ptr;
    assign lif.valid = valid;
    assign lif.addr = addr;
    assign lif.rdata = scaa_pkg::scaa_get_byte(addr, slot);

endmodule

// *** scaa_loc_if.sv ***
// access strobes and state of one port cam location
// assumes both ends run on the same clock
`timescale 1ns/1ps
interface scaa_loc_if;
    logic wr_stb;
    logic rd_stb;
    logic [7:0] wdata;
    logic learn_stb;
    logic [7:0] learn_data;
    logic valid_we;
    logic valid_wdata;
    logic [2:0] ptr;
    logic valid;
    logic [7:0] rdata;
    logic [47:0] addr;

    modport ctrl (output wr_stb, rd_stb, wdata, learn_stb, learn_data, valid_we, valid_wdata,
                  input ptr, valid, rdata, addr);
    modport loc (input wr_stb, rd_stb, wdata, learn_stb, learn_data, valid_we, valid_wdata,
                 output ptr, valid, rdata, addr);
endinterface

// *** scaa_pkg.sv ***
// constants, field layouts and byte helpers for the security cam access block
// assumes a byte-wide processor port with 5-bit register offsets
package scaa_pkg;

    // register offsets
    localparam logic [4:0] OFF_PORT_SECURITY_CONFIG = 5'h11;
    localparam logic [4:0] OFF_PORT_CAM_BYTE_POINTER = 5'h12;
    localparam logic [4:0] OFF_PORT_CAM_DATA_LOC1 = 5'h13;
    localparam logic [4:0] OFF_PORT_CAM_DATA_LOC2 = 5'h14;
    localparam logic [4:0] OFF_SHARED_VALID_LOW = 5'h16;
    localparam logic [4:0] OFF_SHARED_VALID_SECOND = 5'h17;
    localparam logic [4:0] OFF_SHARED_VALID_THIRD = 5'h18;
    localparam logic [4:0] OFF_SHARED_VALID_FOURTH = 5'h19;

    // configuration fields
    localparam int LEARN_ENABLE_BIT = 0;
    localparam int SECURITY_ENABLE_BIT = 1;
    localparam logic [7:0] CONFIG_WRITE_MASK = 8'h6f;

    // pointer register fields
    localparam int LOC1_PTR_LSB = 0;
    localparam int LOC1_VALID_BIT = 3;
    localparam int LOC2_PTR_LSB = 4;
    localparam int LOC2_VALID_BIT = 7;

    // address layout
    localparam int ADDR_BYTES = 6;
    localparam int ADDR_BITS = 48;
    localparam logic [2:0] PTR_FULL = 3'h6;
    localparam logic [2:0] PTR_FIRST = 3'h0;

    // reset values
    localparam logic [7:0] RESET_BYTE = 8'h00;
    localparam logic [47:0] RESET_ADDR = 48'h0000_0000_0000;

    // byte slot that the next access uses; a full pointer restarts at the first byte
    function automatic logic [2:0] scaa_slot(input logic [2:0] ptr);
        scaa_slot = (ptr >= PTR_FULL) ? PTR_FIRST : ptr;
    endfunction

    // pick one address byte, least significant byte first
    function automatic logic [7:0] scaa_get_byte(input logic [47:0] addr, input logic [2:0] idx);
        logic [7:0] b;
        b = RESET_BYTE;
        for (int i = 0; i < ADDR_BYTES; i++) begin
            if (idx == 3'(i)) begin
                b = addr[i*8 +: 8];
            end
        end
        scaa_get_byte = b;
    endfunction

    // replace one address byte
    function automatic logic [47:0] scaa_put_byte(input logic [47:0] addr, input logic [2:0] idx,
                                                 input logic [7:0] b);
        logic [47:0] a;
        a = addr;
        for (int i = 0; i < ADDR_BYTES; i++) begin
            if (idx == 3'(i)) begin
                a[i*8 +: 8] = b;
            end
        end
        scaa_put_byte = a;
    endfunction

endpackage

// *** scaa_props.sv ***
// assertions on the ports of the security cam access block
// assumes binding to scaa_top, one clock, asynchronous active-low reset
`timescale 1ns/1ps
module scaa_props #(
    parameter int SHARED_CAMS = 32
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [4:0] proc_addr,
    input wire logic [7:0] proc_wdata,
    input wire logic proc_write,
    input wire logic proc_read,
    input wire logic [7:0] proc_rdata,
    input wire logic learn_byte_stb,
    input wire logic [7:0] learn_byte,
    input wire logic learn_enable,
    input wire logic security_enable,
    input wire logic [1:0] port_compare_enable,
    input wire logic [95:0] port_cam_address,
    input wire logic [SHARED_CAMS-1:0] shared_compare_enable
);
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!reset_n);
////////////////////////////////////////////////////////////////////////////////
    // configuration bits follow a config write
    cfg_learn_a: assert property (proc_write && proc_addr == 5'h11 |=> learn_enable == $past(proc_wdata[0]))
        else $error("learn enable does not follow config write");
    cfg_security_a: assert property (proc_write && proc_addr == 5'h11
        |=> security_enable == $past(proc_wdata[1]))
        else $error("security enable does not follow config write");
    // shared valid bits map in ascending order and are gated by security
    shared_low_a: assert property (proc_write && proc_addr == 5'h16
        |=> shared_compare_enable[7:0] == ($past(proc_wdata) & {8{security_enable}}))
        else $error("shared cams 1 to 8 do not follow their valid register");
    shared_fourth_a: assert property (proc_write && proc_addr == 5'h19
        |=> shared_compare_enable[31:24] == ($past(proc_wdata) & {8{security_enable}}))
        else $error("shared cams 25 to 32 do not follow their valid register");
    shared_off_a: assert property (!security_enable |-> shared_compare_enable == '0)
        else $error("shared cam compared with security off");
    port_off_a: assert property (!security_enable |-> port_compare_enable == 2'b00)
        else $error("port cam compared with security off");
    // read data stands until the next read
    rdata_hold_a: assert property (!proc_read |=> $stable(proc_rdata))
        else $error("read data changed without a read");
    // addresses change only on a data write or a learned byte
    addr_stable_a: assert property (!learn_byte_stb
        && !(proc_write && (proc_addr == 5'h13 || proc_addr == 5'h14))
        |=> $stable(port_cam_address))
        else $error("port cam address changed without a load");
    cover property (proc_read && proc_addr == 5'h12);
    cover property (learn_byte_stb && learn_enable);
    cover property (port_compare_enable == 2'b11);
endmodule

// *** scaa_top.sv ***
// register access for the port and shared station-address cams of one port
// assumes a byte-wide processor port with single-cycle read and write strobes on mclk
`timescale 1ns/1ps

// Operation
// R1 - each port cam location keeps a byte pointer that steps by one for every byte loaded.
// R2 - the pointer picks the byte that the next data access uses and reads back in the pointer register.
// R3 - software sets a location's valid bit once all six bytes are stored, protecting it from overwrite.
// R4 - while learning is enabled, captured address bytes step the pointer so software can see a learned address.
// R5 - the pointer register holds location 1 pointer in D2-D0 with valid in D3, location 2 in D6-D4 with valid in D7.
// R6 - a location valid bit of 0 means no valid address, 1 means a valid address.
// R7 - a 48-bit address moves in six byte accesses, least significant byte first.
// R8 - shared cams 1-8, 9-16 and 17-24 have valid bits D0-D7 at offsets 16H, 17H and 18H in ascending order.
// R9 - with security enabled only shared cams whose valid bit is 1 take part in comparison.
// R10 - software reads a shared validation register before writing it and changes only its own bits.
// R11 - configuration bit D0 enables learning for the port cams and bit D1 enables security mode.
// R12 - shared cams 25-32 have valid bits D0-D7 at offset 19H with the same meaning.
// R13 - reset clears all pointers and all port and shared valid bits.
module scaa_top #(
    parameter int SHARED_CAMS = 32
) (
    input wire logic mclk,
    input wire logic reset_n,
    input wire logic [4:0] proc_addr,
    input wire logic [7:0] proc_wdata,
    input wire logic proc_write,
    input wire logic proc_read,
    output logic [7:0] proc_rdata,
    input wire logic learn_byte_stb,
    input wire logic [7:0] learn_byte,
    output logic learn_enable,
    output logic security_enable,
    output logic [1:0] port_compare_enable,
    output logic [95:0] port_cam_address,
    output logic [SHARED_CAMS-1:0] shared_compare_enable
);

    logic [7:0] config_reg;
    logic [7:0] next_config_reg;
    logic [SHARED_CAMS-1:0] shared_valid;
    logic [SHARED_CAMS-1:0] next_shared_valid;
    logic [7:0] next_proc_rdata;
    logic [7:0] pointer_view;
    logic [1:0] learn_target;

    scaa_loc_if loc_bus [2] ();

    ////////////////////////////////////////////////////////////////////////
    // the two port cam locations
    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gen_loc
            localparam logic [4:0] DATA_OFF = (g == 0) ? scaa_pkg::OFF_PORT_CAM_DATA_LOC1
                                                       : scaa_pkg::OFF_PORT_CAM_DATA_LOC2;
            localparam int VALID_BIT = (g == 0) ? scaa_pkg::LOC1_VALID_BIT : scaa_pkg::LOC2_VALID_BIT;

            // processor strobes for this location's data register
            assign loc_bus[g].wr_stb = proc_write && (proc_addr == DATA_OFF);
            assign loc_bus[g].rd_stb = proc_read && (proc_addr == DATA_OFF);
            assign loc_bus[g].wdata = proc_wdata;
            // valid bit written through the pointer register [R3]
            assign loc_bus[g].valid_we = proc_write && (proc_addr == scaa_pkg::OFF_PORT_CAM_BYTE_POINTER);
            assign loc_bus[g].valid_wdata = proc_wdata[VALID_BIT];
            // learned bytes go only to the chosen location [R4]
            assign loc_bus[g].learn_stb = learn_byte_stb && learn_enable && learn_target[g];
            assign loc_bus[g].learn_data = learn_byte;

            scaa_cam_loc u_loc (
                .mclk(mclk),
                .reset_n(reset_n),
                .lif(loc_bus[g])
            );

            // address and comparison qualifier for the comparator
            assign port_cam_address[g*48 +: 48] = loc_bus[g].addr;
            assign port_compare_enable[g] = security_enable && loc_bus[g].valid;
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////
    // learning fills location 1 first, then location 2, never a valid or full one
    always_comb begin
        learn_target = 2'b00;
        if (!loc_bus[0].valid && loc_bus[0].ptr != scaa_pkg::PTR_FULL) begin
            learn_target = 2'b01;
        end else if (!loc_bus[1].valid && loc_bus[1].ptr != scaa_pkg::PTR_FULL) begin
            learn_target = 2'b10;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // pointer register view
    always_comb begin
        pointer_view = scaa_pkg::RESET_BYTE;
        pointer_view[scaa_pkg::LOC1_PTR_LSB +: 3] = loc_bus[0].ptr; // [R5] [R2]
        pointer_view[scaa_pkg::LOC1_VALID_BIT] = loc_bus[0].valid; // [R5]
        pointer_view[scaa_pkg::LOC2_PTR_LSB +: 3] = loc_bus[1].ptr; // [R5] [R2]
        pointer_view[scaa_pkg::LOC2_VALID_BIT] = loc_bus[1].valid; // [R5]
    end

    ////////////////////////////////////////////////////////////////////////
    // shared validation register decode, used by the write and the read path
    function automatic logic scaa_shared_hit(input logic [4:0] addr, input int r);
        scaa_shared_hit = (addr == scaa_pkg::OFF_SHARED_VALID_LOW + 5'(r));
    endfunction

    ////////////////////////////////////////////////////////////////////////
    // configuration and shared valid registers, next values
    always_comb begin
        next_config_reg = config_reg;
        next_shared_valid = shared_valid;
        if (proc_write) begin
            if (proc_addr == scaa_pkg::OFF_PORT_SECURITY_CONFIG) begin
                next_config_reg = proc_wdata & scaa_pkg::CONFIG_WRITE_MASK; // [R11]
            end
            // each validation register owns eight shared cams in ascending order
            for (int r = 0; r < SHARED_CAMS / 8; r++) begin
                if (scaa_shared_hit(proc_addr, r)) begin
                    next_shared_valid[r*8 +: 8] = proc_wdata; // [R8] [R12]
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // read data mux, registered one cycle after the read strobe
    always_comb begin
        next_proc_rdata = proc_rdata;
        if (proc_read) begin
            next_proc_rdata = scaa_pkg::RESET_BYTE; // unmapped offsets read zero
            case (proc_addr)
                scaa_pkg::OFF_PORT_SECURITY_CONFIG: begin
                    next_proc_rdata = config_reg;
                end
                scaa_pkg::OFF_PORT_CAM_BYTE_POINTER: begin
                    next_proc_rdata = pointer_view; // [R2] [R4]
                end
                scaa_pkg::OFF_PORT_CAM_DATA_LOC1: begin
                    next_proc_rdata = loc_bus[0].rdata; // [R7]
                end
                scaa_pkg::OFF_PORT_CAM_DATA_LOC2: begin
                    next_proc_rdata = loc_bus[1].rdata; // [R7]
                end
                default: begin
                    for (int r = 0; r < SHARED_CAMS / 8; r++) begin
                        if (scaa_shared_hit(proc_addr, r)) begin
                            next_proc_rdata = shared_valid[r*8 +: 8]; // [R8] [R12]
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // register bank flops
    always_ff @(posedge mclk or negedge reset_n) begin
        if (!reset_n) begin
            config_reg <= scaa_pkg::RESET_BYTE;
            shared_valid <= '0; // [R13]
            proc_rdata <= scaa_pkg::RESET_BYTE;
        end else begin
            config_reg <= next_config_reg;
            shared_valid <= next_shared_valid;
            proc_rdata <= next_proc_rdata;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // mode outputs and shared comparison qualifiers
    assign learn_enable = config_reg[scaa_pkg::LEARN_ENABLE_BIT]; // [R11]
    assign security_enable = config_reg[scaa_pkg::SECURITY_ENABLE_BIT]; // [R11]
    assign shared_compare_enable = security_enable ? shared_valid : '0; // [R9]

endmodule

// *** tb.sv ***
// self-checking bench for the security cam access block
// assumes scaa_top and scaa_props are compiled beforehand
`timescale 1ns/1ps
module tb;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [4:0] proc_addr = 5'h00;
    logic [7:0] proc_wdata = 8'h00;
    logic proc_write = 1'b0;
    logic proc_read = 1'b0;
    logic learn_byte_stb = 1'b0;
    logic [7:0] learn_byte = 8'h00;
    logic [7:0] proc_rdata;
    logic learn_enable;
    logic security_enable;
    logic [1:0] port_compare_enable;
    logic [95:0] port_cam_address;
    logic [31:0] shared_compare_enable;
    logic [31:0] exp_shared = 32'h0000_0000;
    logic [47:0] addr_a = 48'ha1b2_c3d4_e5f6;
    logic [47:0] addr_b = 48'h1122_3344_5566;
    int fail_count = 0;
    int comparisons = 0;
    // 250 MHz clock
    always #2 mclk = ~mclk;
    scaa_top #(.SHARED_CAMS(32)) dut (.mclk(mclk), .reset_n(reset_n), .proc_addr(proc_addr),
        .proc_wdata(proc_wdata), .proc_write(proc_write), .proc_read(proc_read), .proc_rdata(proc_rdata),
        .learn_byte_stb(learn_byte_stb), .learn_byte(learn_byte), .learn_enable(learn_enable),
        .security_enable(security_enable), .port_compare_enable(port_compare_enable),
        .port_cam_address(port_cam_address), .shared_compare_enable(shared_compare_enable));
////////////////////////////////////////////////////////////////////////////////
    // compare, counting every check
    task automatic chk(input string name, input logic [95:0] exp, input logic [95:0] got);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %h seen %h", name, exp, got);
        end
    endtask
    // one-cycle strobes, settled one ns after the taking edge
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk);
        proc_addr <= a;
        proc_wdata <= d;
        proc_write <= 1'b1;
        @(posedge mclk);
        proc_write <= 1'b0;
        #1;
    endtask
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        @(posedge mclk);
        proc_addr <= a;
        proc_read <= 1'b1;
        @(posedge mclk);
        proc_read <= 1'b0;
        #1;
        chk("read data", 96'(exp), 96'(proc_rdata));
    endtask
    task automatic learn(input logic [7:0] b);
        @(posedge mclk);
        learn_byte <= b;
        learn_byte_stb <= 1'b1;
        @(posedge mclk);
        learn_byte_stb <= 1'b0;
        #1;
    endtask
    // everything cleared: outputs and every register that does not step
    task automatic zero_check();
        logic [4:0] regs [6];
        regs = '{5'h11, 5'h12, 5'h16, 5'h17, 5'h18, 5'h19};
        chk("outputs", 96'h0,
            96'({learn_enable, security_enable, port_compare_enable, shared_compare_enable}));
        chk("addresses", 96'h0, port_cam_address);
        foreach (regs[i]) rd(regs[i], 8'h00);
    endtask
    task automatic results();
        $display("mismatches %0d comparisons %0d", fail_count, comparisons);
        if (fail_count == 0 && comparisons > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
////////////////////////////////////////////////////////////////////////////////
    // watchdog
    initial begin
        #20000;
        fail_count++;
        results();
    end
    // test sequence
    initial begin
        repeat (6) @(posedge mclk);
        reset_n <= 1'b1;
        zero_check();
        wr(5'h11, 8'hff);
        rd(5'h11, 8'h6f);
        chk("learn and security", 96'({learn_enable, security_enable}), 96'h3);
        for (int i = 0; i < 6; i++) begin
            wr(5'h13, addr_a[i*8 +: 8]);
            rd(5'h12, {5'h00, 3'(i + 1)});
        end
        chk("location one", 96'(addr_a), 96'(port_cam_address[47:0]));
        wr(5'h12, 8'h08);
        rd(5'h12, 8'h0e);
        chk("compare enable", 96'h1, 96'(port_compare_enable));
        wr(5'h13, 8'h5a);
        chk("protected address", 96'(addr_a), 96'(port_cam_address[47:0]));
        for (int i = 0; i < 6; i++) begin
            rd(5'h13, addr_a[i*8 +: 8]);
        end
        for (int i = 0; i < 6; i++) begin
            learn(addr_b[i*8 +: 8]);
        end
        rd(5'h12, 8'h6e);
        learn(8'hee);
        wr(5'h12, 8'h88);
        rd(5'h12, 8'hee);
        chk("both locations", {addr_b, addr_a}, port_cam_address);
        chk("compare enable", 96'h3, 96'(port_compare_enable));
        // location 2 read back through its own data register
        for (int i = 0; i < 6; i++) begin
            rd(5'h14, addr_b[i*8 +: 8]);
        end
        for (int i = 0; i < 4; i++) begin
            exp_shared[i*8 +: 8] = 8'h81 ^ 8'(i * 17);
            wr(5'h16 + 5'(i), exp_shared[i*8 +: 8]);
            rd(5'h16 + 5'(i), exp_shared[i*8 +: 8]);
        end
        // read-modify-write that adds one shared cam and keeps the others
        rd(5'h17, exp_shared[15:8]);
        exp_shared[9] = 1'b1;
        wr(5'h17, exp_shared[15:8]);
        chk("shared enable", 96'(exp_shared), 96'(shared_compare_enable));
        wr(5'h15, 8'hff);
        rd(5'h15, 8'h00);
        rd(5'h1f, 8'h00);
        wr(5'h11, 8'h01);
        chk("security off", 96'h0, 96'({port_compare_enable, shared_compare_enable}));
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        zero_check();
        // learning off drops a byte, learning on fills location 1, location 2 takes a processor write
        learn(8'h77);
        chk("learn off", 96'h0, port_cam_address);
        wr(5'h11, 8'h01);
        learn(8'h77);
        wr(5'h14, 8'h42);
        rd(5'h12, 8'h11);
        chk("first bytes", 96'h0000_0000_0042_0000_0000_0077, port_cam_address);
        results();
    end
endmodule

bind scaa_top scaa_props #(.SHARED_CAMS(SHARED_CAMS)) props (.mclk(mclk), .reset_n(reset_n),
    .proc_addr(proc_addr), .proc_wdata(proc_wdata), .proc_write(proc_write), .proc_read(proc_read),
    .proc_rdata(proc_rdata), .learn_byte_stb(learn_byte_stb), .learn_byte(learn_byte),
    .learn_enable(learn_enable), .security_enable(security_enable), .port_compare_enable(port_compare_enable),
    .port_cam_address(port_cam_address), .shared_compare_enable(shared_compare_enable));
